// ---- design/urx_receiver.sv ----
// Purpose: Asynchronous serial receiver with status, error flags and buffer
// Assumes: sample_tick pulses one clock at 16x (or 8x) the baud rate
// Notes: Error flags travel with each character through the buffer
// Contract
// - Complete flag shows buffer holds unread data
// - Clearing enable flushes buffer, clears flag
// - Interrupt request is level while flag set
// - Errors stored per character, data read advances
// - Software writes never change error flags
// - Error flags raise no interrupt
// - Frame error is inverted first stop bit
// - Only first stop bit examined
// - Overrun on full buffer, waiting char, start
// - Overrun cleared on successful buffer transfer
// - Parity checked odd or even when enabled
// - Parity error only when checking was enabled
// - Disable is immediate, drops reception, releases pin
// - Sample at 16x, or 8x double speed
// - Start voted on samples 8-10 or 4-6
// - Sixteen or eight sample states per bit
// - Each bit is majority of three samples
// - Next start searchable right after stop vote
// - Complete frame moves into receive buffer
// - Unused high data bits read zero
// - Enable takes over the input pin
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module urx_receiver
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Serial line
  input wire logic serial_input_pin,
  input wire logic sample_tick,
  output logic pin_override,
  // Interrupt request
  output logic rx_irq
);

  // Control bits
  logic double_speed_select, rx_complete_irq_enable, rx_enable_bit;
  logic parity_enable_bit, parity_odd_select, two_stop_select;
  logic [2:0] char_size_field;
  // Recovery
  urx_pkg::urx_state_type state;
  logic line_sync, line, decide, bit_val, start_edge, par_bad, par_seen;
  logic [2:0] vote;
  logic [4:0] cnt, cnt_nx, spb, vote_last;
  logic [3:0] idx, nbits, stop_idx;
  logic [8:0] shift;
  // Held frame and buffer
  logic pending, pend_fe, pend_pe, ovr_lost, fifo_full, fifo_empty;
  logic push, pop, rx_complete_flag, frame_done;
  logic [urx_pkg::ENTRY_W-1:0] head;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    if (sz == urx_pkg::CSZ_NINE)
    begin
      data_bits = urx_pkg::BITS_NINE;
    end
    else
    begin
      data_bits = urx_pkg::BITS_BASE + {2'b00, sz[1:0]};
    end
  endfunction

  urx_sync2 u_sync
  (
    .clk(clk),
    .srst(srst),
    .din(serial_input_pin),
    .dout(line_sync)
  );

  // Line looks idle while the receiver does not own the pin
  assign line = rx_enable_bit ? line_sync : 1'b1;
  assign pin_override = rx_enable_bit;

  assign spb = double_speed_select ? urx_pkg::DOUBLE_SPB : urx_pkg::NORMAL_SPB;
  assign vote_last = (double_speed_select ? urx_pkg::DOUBLE_FIRST_VOTE
                                          : urx_pkg::NORMAL_FIRST_VOTE) + urx_pkg::VOTE_SPAN;
  assign cnt_nx = (cnt == spb) ? urx_pkg::FIRST_SAMPLE : cnt + urx_pkg::FIRST_SAMPLE;
  assign decide = sample_tick && (state != urx_pkg::URX_IDLE) && (cnt_nx == vote_last);
  assign bit_val = maj3(vote[1], vote[0], line);
  assign start_edge = sample_tick && (state == urx_pkg::URX_IDLE) && vote[0] && !line;
  assign nbits = data_bits(char_size_field);
  // Only the first stop bit is voted; a second one is just idle line
  assign stop_idx = nbits + {3'b000, parity_enable_bit};
  assign frame_done = decide && (state == urx_pkg::URX_BITS) && (idx == stop_idx);
  assign par_bad = parity_enable_bit && (bit_val != ((^shift) ^ parity_odd_select));

  // Register writes; error flags have no write path
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      double_speed_select <= urx_pkg::RESET_BIT;
      rx_complete_irq_enable <= urx_pkg::RESET_BIT;
      rx_enable_bit <= urx_pkg::RESET_BIT;
      parity_enable_bit <= urx_pkg::RESET_BIT;
      parity_odd_select <= urx_pkg::RESET_BIT;
      two_stop_select <= urx_pkg::RESET_BIT;
      char_size_field <= urx_pkg::CSZ_RESET;
    end
    else if (wr)
    begin
      case (addr)
        urx_pkg::ADDR_STATUS:
        begin
          double_speed_select <= wdata[urx_pkg::STATUS_U2X_BIT];
        end
        urx_pkg::ADDR_CTRL_B:
        begin
          rx_complete_irq_enable <= wdata[urx_pkg::CTRL_B_IRQ_EN_BIT];
          rx_enable_bit <= wdata[urx_pkg::CTRL_B_RXEN_BIT];
        end
        urx_pkg::ADDR_CTRL_C:
        begin
          parity_enable_bit <= wdata[urx_pkg::CTRL_C_PAR_EN_BIT];
          parity_odd_select <= wdata[urx_pkg::CTRL_C_PAR_ODD_BIT];
          two_stop_select <= wdata[urx_pkg::CTRL_C_TWO_STOP_BIT];
          char_size_field <= wdata[urx_pkg::CTRL_C_CSZ_LSB+:3];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Sample history, shifted on every tick
  always_ff @(posedge clk)
  begin
    if (srst || !rx_enable_bit)
    begin
      vote <= 3'h7;
    end
    else if (sample_tick)
    begin
      vote <= {vote[1:0], line};
    end
  end

  // Clock and data recovery
  always_ff @(posedge clk)
  begin
    if (srst || !rx_enable_bit)
    begin
      state <= urx_pkg::URX_IDLE;
      cnt <= 5'h00;
      idx <= 4'h0;
    end
    else
    begin
      case (state)
        urx_pkg::URX_IDLE:
        begin
          if (start_edge)
          begin
            state <= urx_pkg::URX_START;
            cnt <= urx_pkg::FIRST_SAMPLE;
            idx <= 4'h0;
          end
        end
        urx_pkg::URX_START:
        begin
          if (sample_tick)
          begin
            cnt <= cnt_nx;
          end
          if (decide)
          begin
            // A high majority means a noise spike
            state <= bit_val ? urx_pkg::URX_IDLE : urx_pkg::URX_BITS;
          end
        end
        urx_pkg::URX_BITS:
        begin
          if (sample_tick)
          begin
            cnt <= cnt_nx;
          end
          if (frame_done)
          begin
            // Back to search right after the stop vote
            state <= urx_pkg::URX_IDLE;
          end
          else if (decide)
          begin
            idx <= idx + 4'h1;
          end
        end
        default:
        begin
          state <= urx_pkg::URX_IDLE;
        end
      endcase
    end
  end

  // Shift register; cleared per frame so short characters read zero on top
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shift <= 9'h000;
    end
    else if (start_edge)
    begin
      shift <= 9'h000;
    end
    else if (decide && (state == urx_pkg::URX_BITS) && (idx < nbits))
    begin
      shift[idx] <= bit_val;
    end
  end

  // Finished frame waits here until the buffer has room
  always_ff @(posedge clk)
  begin
    if (srst || !rx_enable_bit)
    begin
      pending <= 1'b0;
      pend_fe <= 1'b0;
      pend_pe <= 1'b0;
      par_seen <= 1'b0;
      ovr_lost <= 1'b0;
    end
    else
    begin
      if (decide && (state == urx_pkg::URX_BITS) && (idx == nbits))
      begin
        par_seen <= par_bad;
      end
      if (frame_done)
      begin
        pending <= 1'b1;
        pend_fe <= !bit_val;
        pend_pe <= parity_enable_bit && par_seen;
      end
      else if (push || (start_edge && fifo_full))
      begin
        // An overrun drops the waiting character
        pending <= 1'b0;
      end
      if (start_edge && pending && fifo_full)
      begin
        ovr_lost <= 1'b1;
      end
      else if (push)
      begin
        ovr_lost <= 1'b0;
      end
    end
  end

  assign push = pending && !fifo_full;
  assign pop = rd && (addr == urx_pkg::ADDR_DATA);

  urx_rx_fifo u_fifo
  (
    .clk(clk),
    .srst(srst),
    .flush(!rx_enable_bit),
    .push(push),
    .push_data({pend_pe, ovr_lost, pend_fe, shift}),
    .full(fifo_full),
    .pop(pop),
    .head(head),
    .empty(fifo_empty)
  );

  assign rx_complete_flag = !fifo_empty;
  // Only the complete flag reaches the request line
  assign rx_irq = rx_complete_irq_enable && rx_complete_flag;

  // Read data: valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clk)
  begin
    if (srst || !rd)
    begin
      rdata <= urx_pkg::RDATA_IDLE;
    end
    else
    begin
      rdata <= urx_pkg::RDATA_IDLE;
      case (addr)
        urx_pkg::ADDR_STATUS:
        begin
          rdata[urx_pkg::STATUS_RXC_BIT] <= rx_complete_flag;
          rdata[urx_pkg::STATUS_FE_BIT] <= rx_complete_flag && head[urx_pkg::ENTRY_FE_BIT];
          rdata[urx_pkg::STATUS_DOR_BIT] <= rx_complete_flag && head[urx_pkg::ENTRY_DOR_BIT];
          rdata[urx_pkg::STATUS_PE_BIT] <= rx_complete_flag && head[urx_pkg::ENTRY_PE_BIT];
          rdata[urx_pkg::STATUS_U2X_BIT] <= double_speed_select;
        end
        urx_pkg::ADDR_CTRL_B:
        begin
          rdata[urx_pkg::CTRL_B_IRQ_EN_BIT] <= rx_complete_irq_enable;
          rdata[urx_pkg::CTRL_B_RXEN_BIT] <= rx_enable_bit;
          rdata[urx_pkg::CTRL_B_RXB8_BIT] <= rx_complete_flag && head[8];
        end
        urx_pkg::ADDR_CTRL_C:
        begin
          rdata[urx_pkg::CTRL_C_PAR_EN_BIT] <= parity_enable_bit;
          rdata[urx_pkg::CTRL_C_PAR_ODD_BIT] <= parity_odd_select;
          rdata[urx_pkg::CTRL_C_TWO_STOP_BIT] <= two_stop_select;
          rdata[urx_pkg::CTRL_C_CSZ_LSB+:3] <= char_size_field;
        end
        urx_pkg::ADDR_DATA:
        begin
          rdata <= rx_complete_flag ? head[7:0] : urx_pkg::RDATA_IDLE;
        end
        default:
        begin
          rdata <= urx_pkg::RDATA_IDLE;
        end
      endcase
    end
  end

  // Checks
  flush_on_disable_a: assert property (@(posedge clk) disable iff (srst)
    !rx_enable_bit |=> !rx_complete_flag && !rx_irq && state == urx_pkg::URX_IDLE)
    else $error("receiver not flushed after disable");
  irq_level_a: assert property (@(posedge clk) disable iff (srst)
    (rx_complete_irq_enable && !fifo_empty) |-> rx_irq)
    else $error("interrupt request missing while data buffered");
  irq_errors_a: assert property (@(posedge clk) disable iff (srst)
    fifo_empty |-> !rx_irq)
    else $error("interrupt request without buffered data");
  frame_error_a: assert property (@(posedge clk) disable iff (srst || !rx_enable_bit)
    frame_done |=> pending && (pend_fe == !$past(bit_val)))
    else $error("frame error does not match stop bit");
  overrun_set_a: assert property (@(posedge clk) disable iff (srst || !rx_enable_bit)
    (start_edge && pending && fifo_full) |=> ovr_lost && !pending)
    else $error("overrun not flagged");
  overrun_clear_a: assert property (@(posedge clk) disable iff (srst)
    (push && !start_edge && rx_enable_bit) |=> !ovr_lost)
    else $error("overrun not cleared on transfer");
  parity_off_a: assert property (@(posedge clk) disable iff (srst || !rx_enable_bit)
    (frame_done && !parity_enable_bit) |=> !pend_pe)
    else $error("parity error without checking");
  sample_range_a: assert property (@(posedge clk) disable iff (srst)
    (state != urx_pkg::URX_IDLE) |-> (cnt >= urx_pkg::FIRST_SAMPLE) && (cnt <= spb))
    else $error("sample counter out of range");
  spike_reject_a: assert property (@(posedge clk) disable iff (srst || !rx_enable_bit)
    (decide && state == urx_pkg::URX_START && bit_val) |=> state == urx_pkg::URX_IDLE)
    else $error("noise spike accepted as start");
  stop_rearm_a: assert property (@(posedge clk) disable iff (srst || !rx_enable_bit)
    frame_done |=> state == urx_pkg::URX_IDLE)
    else $error("receiver not searching after stop vote");

endmodule

// ---- design/urx_pkg.sv ----
// Purpose: Shared constants and types for the receive half of the serial port
// Assumes: Registers sit on a 2-bit byte-wide plain register port
// Notes: Sample counts are in sample ticks, not system clocks
package urx_pkg;

  // Register offsets
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CTRL_B = 2'h1;
  localparam logic [1:0] ADDR_CTRL_C = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;

  // Bit positions, ctrl_status_a
  localparam int STATUS_RXC_BIT = 7;
  localparam int STATUS_FE_BIT = 4;
  localparam int STATUS_DOR_BIT = 3;
  localparam int STATUS_PE_BIT = 2;
  localparam int STATUS_U2X_BIT = 1;

  // Bit positions, ctrl_status_b
  localparam int CTRL_B_IRQ_EN_BIT = 7;
  localparam int CTRL_B_RXEN_BIT = 4;
  localparam int CTRL_B_RXB8_BIT = 1;

  // Bit positions, ctrl_status_c
  localparam int CTRL_C_PAR_EN_BIT = 5;
  localparam int CTRL_C_PAR_ODD_BIT = 4;
  localparam int CTRL_C_TWO_STOP_BIT = 3;
  localparam int CTRL_C_CSZ_LSB = 0;

  // Reset values
  localparam logic RESET_BIT = 1'h0;
  localparam logic [2:0] CSZ_RESET = 3'h3;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Character size codes
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [3:0] BITS_BASE = 4'h5;

  // Oversampling
  localparam logic [4:0] NORMAL_SPB = 5'h10;
  localparam logic [4:0] DOUBLE_SPB = 5'h08;
  localparam logic [4:0] NORMAL_FIRST_VOTE = 5'h08;
  localparam logic [4:0] DOUBLE_FIRST_VOTE = 5'h04;
  localparam logic [4:0] VOTE_SPAN = 5'h02;
  localparam logic [4:0] FIRST_SAMPLE = 5'h01;

  // Receive buffer entry layout
  localparam int ENTRY_W = 12;
  localparam int ENTRY_FE_BIT = 9;
  localparam int ENTRY_DOR_BIT = 10;
  localparam int ENTRY_PE_BIT = 11;
  localparam int FIFO_DEPTH = 2;

  typedef enum logic [1:0]
  {
    URX_IDLE = 2'b00,
    URX_START = 2'b01,
    URX_BITS = 2'b10
  } urx_state_type;

endpackage

// ---- design/urx_sync2.sv ----
// Purpose: Two-stage synchroniser for the serial input
// Assumes: Line idles high
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module urx_sync2
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Line
  input wire logic din,
  output logic dout
);

  logic meta;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ---- design/urx_rx_fifo.sv ----
// Purpose: Two-entry receive buffer holding character and its error bits
// Assumes: Writer pushes only when not full
// Notes: Flush empties it in one cycle
`timescale 1ns/1ps
module urx_rx_fifo
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  // Fill side
  input wire logic push,
  input wire logic [urx_pkg::ENTRY_W-1:0] push_data,
  output logic full,
  // Drain side
  input wire logic pop,
  output logic [urx_pkg::ENTRY_W-1:0] head,
  output logic empty
);

  logic [urx_pkg::ENTRY_W-1:0] mem [urx_pkg::FIFO_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic do_push;
  logic do_pop;

  assign full = (count == 2'h2);
  assign empty = (count == 2'h0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (srst || flush)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= !wr_ptr;
      end
      if (do_pop)
      begin
        rd_ptr <= !rd_ptr;
      end
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_data;
    end
  end

  read_advance_a: assert property (@(posedge clk) disable iff (srst || flush)
    (pop && full) |=> !full && !empty)
    else $error("data read did not advance buffer");

endmodule

// ---- testbench/urx_tx_model.sv ----
// Purpose: Behavioural remote serial transmitter driving the receive line
// Assumes: tick is the receiver's sample tick; spb ticks make one bit
// Notes: Line returns to its idle high level between frames
`timescale 1ns/1ps
module urx_tx_model
(
  // Clock
  input wire logic clk,
  input wire logic tick,
  // Frame request
  input wire logic go,
  input wire logic [11:0] frame,
  input wire logic [3:0] nbits,
  input wire logic [4:0] spb,
  input wire logic short_stop,
  input wire logic spike,
  // Line and status
  output logic line,
  output logic busy,
  output logic taken
);
  logic [11:0] sh;
  logic [3:0] left;
  logic [4:0] cnt;
  logic [4:0] len;
  logic free;

  assign free = !busy || (cnt == len && left == 4'h0);

  initial
  begin
    line = 1'b1;
    busy = 1'b0;
    taken = 1'b0;
  end

  always @(posedge clk)
  begin
    taken <= 1'b0;
    if (tick && free && go)
    begin
      // A spike is a short low pulse with no frame behind it
      busy <= 1'b1;
      taken <= 1'b1;
      sh <= frame;
      line <= 1'b0;
      cnt <= 5'h01;
      left <= spike ? 4'h0 : nbits;
      len <= spike ? 5'h05 : spb;
    end
    else if (tick && free)
    begin
      line <= 1'b1;
      busy <= 1'b0;
    end
    else if (tick && cnt != len)
      cnt <= cnt + 5'h01;
    else if (tick)
    begin
      line <= sh[0];
      sh <= sh >> 1;
      left <= left - 4'h1;
      cnt <= 5'h01;
      // Short stop puts the next start right after the stop vote
      len <= (left == 4'h1 && short_stop) ? 5'h0a : spb;
    end
  end
endmodule

// ---- testbench/uart_receiver_status_recovery_bench.sv ----
// Purpose: Self-checking bench for the serial receiver block
// Assumes: Sample tick every 4 clocks; far end is urx_tx_model
// Notes: Status, data and control are checked over the register port
`timescale 1ns/1ps
module uart_receiver_status_recovery_bench;
  localparam logic [7:0] F_DONE = 8'h01 << urx_pkg::STATUS_RXC_BIT;
  localparam logic [7:0] F_FRM = 8'h01 << urx_pkg::STATUS_FE_BIT;
  localparam logic [7:0] F_OVR = 8'h01 << urx_pkg::STATUS_DOR_BIT;
  localparam logic [7:0] F_PAR = 8'h01 << urx_pkg::STATUS_PE_BIT;
  localparam logic [7:0] F_DBL = 8'h01 << urx_pkg::STATUS_U2X_BIT;
  localparam logic [7:0] C_IEN = 8'h01 << urx_pkg::CTRL_B_IRQ_EN_BIT;
  localparam logic [7:0] C_REN = 8'h01 << urx_pkg::CTRL_B_RXEN_BIT;
  localparam logic [7:0] C_NINE = 8'h01 << urx_pkg::CTRL_B_RXB8_BIT;
  localparam logic [7:0] C_PEN = 8'h01 << urx_pkg::CTRL_C_PAR_EN_BIT;
  localparam logic [7:0] C_ODD = 8'h01 << urx_pkg::CTRL_C_PAR_ODD_BIT;
  localparam logic [7:0] C_TWO = 8'h01 << urx_pkg::CTRL_C_TWO_STOP_BIT;
  localparam logic [7:0] C_CSZ8 = {5'h00, urx_pkg::CSZ_RESET};

  logic clk, srst, wr, rd, sample_tick, pin, pov, irq;
  logic go, short_stop, spike, busy, taken;
  logic [1:0] addr, tdiv;
  logic [7:0] wdata, rdata;
  logic [11:0] fr;
  logic [3:0] nb;
  logic [4:0] spb;
  logic [2:0] csz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, urx_pkg::CSZ_NINE};
  int n_errors, compares, k, nd;

  urx_receiver dut_u
  (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_input_pin(pin), .sample_tick(sample_tick), .pin_override(pov), .rx_irq(irq)
  );

  urx_tx_model tx_u
  (
    .clk(clk), .tick(sample_tick), .go(go), .frame(fr), .nbits(nb), .spb(spb),
    .short_stop(short_stop), .spike(spike), .line(pin), .busy(busy), .taken(taken)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    tdiv <= tdiv + 2'h1;
    sample_tick <= (tdiv == 2'h3);
  end

  task automatic close_out;
    $display("checks %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let the write settle before any output is looked at
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(what, exp, rdata);
  endtask

  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic odd,
    input logic flip, input logic stop);
    logic [11:0] f;
    logic p;
    int i;
    f = '0;
    p = odd ^ flip;
    for (i = 0; i < n; i++)
    begin
      f[i] = d[i];
      p = p ^ d[i];
    end
    if (pen)
    begin
      f[i] = p;
      i++;
    end
    f[i] = stop;
    @(posedge clk);
    fr <= f;
    nb <= 4'(i + 1);
    go <= 1'b1;
    do @(posedge clk); while (taken !== 1'b1);
  endtask

  task automatic settle;
    @(posedge clk);
    go <= 1'b0;
    short_stop <= 1'b0;
    do @(posedge clk); while (busy);
    repeat (80) @(posedge clk);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    close_out;
  end

  initial
  begin
    {srst, wr, rd, sample_tick, go, short_stop, spike} = 7'h01 << 6;
    {addr, tdiv, wdata, fr, nb} = '0;
    spb = urx_pkg::NORMAL_SPB;
    n_errors = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "status");
    rchk(urx_pkg::ADDR_CTRL_B, 8'h00, "ctrl_b");
    rchk(urx_pkg::ADDR_CTRL_C, C_CSZ8, "ctrl_c");
    rchk(urx_pkg::ADDR_DATA, 8'h00, "empty data");
    chk1("pin_override", 1'b0, pov);
    $display("test reset done");
    wreg(urx_pkg::ADDR_CTRL_B, C_IEN | C_REN);
    chk1("pin_override", 1'b1, pov);
    send(9'h0a5, 8, 0, 0, 0, 1);
    settle;
    chk1("rx_irq", 1'b1, irq);
    rchk(urx_pkg::ADDR_STATUS, F_DONE, "status");
    rchk(urx_pkg::ADDR_DATA, 8'ha5, "data");
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "status");
    chk1("rx_irq", 1'b0, irq);
    $display("test basic done");
    wreg(urx_pkg::ADDR_CTRL_B, C_REN);
    wreg(urx_pkg::ADDR_CTRL_C, C_TWO | C_CSZ8);
    send(9'h03c, 8, 0, 0, 0, 0);
    settle;
    chk1("rx_irq", 1'b0, irq);
    wreg(urx_pkg::ADDR_STATUS, F_FRM | F_OVR | F_PAR);
    rchk(urx_pkg::ADDR_STATUS, F_DONE | F_FRM, "frame error");
    rchk(urx_pkg::ADDR_DATA, 8'h3c, "data");
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "status");
    $display("test frame error done");
    wreg(urx_pkg::ADDR_CTRL_B, C_IEN | C_REN);
    for (k = 0; k < 4; k++)
    begin
      wreg(urx_pkg::ADDR_CTRL_C, C_PEN | (k[0] ? C_ODD : 8'h00) | C_CSZ8);
      send({1'b0, 8'h5a + 8'(k)}, 8, 1, k[0], k[1], 1);
      settle;
      rchk(urx_pkg::ADDR_STATUS, k[1] ? F_DONE | F_PAR : F_DONE, "parity");
      chk1("rx_irq", 1'b1, irq);
      rchk(urx_pkg::ADDR_DATA, 8'h5a + 8'(k), "parity data");
    end
    $display("test parity done");
    for (k = 0; k < 5; k++)
    begin
      wreg(urx_pkg::ADDR_CTRL_C, {5'h00, csz[k]});
      nd = (csz[k] == urx_pkg::CSZ_NINE) ? 9 : int'(csz[k]) + 5;
      send(9'h1c6, nd, 0, 0, 0, 1);
      settle;
      rchk(urx_pkg::ADDR_STATUS, F_DONE, "size status");
      if (nd == 9) rchk(urx_pkg::ADDR_CTRL_B, C_IEN | C_REN | C_NINE, "ninth");
      rchk(urx_pkg::ADDR_DATA, 8'hc6 & (8'hff >> (8 - (nd > 8 ? 8 : nd))), "size");
    end
    $display("test sizes done");
    wreg(urx_pkg::ADDR_CTRL_C, C_CSZ8);
    @(posedge clk);
    spike <= 1'b1;
    go <= 1'b1;
    do @(posedge clk); while (taken !== 1'b1);
    go <= 1'b0;
    spike <= 1'b0;
    repeat (200) @(posedge clk);
    send(9'h0c3, 8, 0, 0, 0, 1);
    settle;
    rchk(urx_pkg::ADDR_DATA, 8'hc3, "after spike");
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "after spike");
    $display("test spike done");
    // Four frames with shortest stops: two buffered, one held, one overruns
    short_stop <= 1'b1;
    for (k = 1; k < 5; k++)
      send({1'b0, 8'h11 * 8'(k)}, 8, 0, 0, 0, 1);
    settle;
    rchk(urx_pkg::ADDR_STATUS, F_DONE, "first entry");
    rchk(urx_pkg::ADDR_DATA, 8'h11, "first data");
    rchk(urx_pkg::ADDR_STATUS, F_DONE, "second entry");
    rchk(urx_pkg::ADDR_DATA, 8'h22, "second data");
    rchk(urx_pkg::ADDR_STATUS, F_DONE | F_OVR, "overrun");
    rchk(urx_pkg::ADDR_DATA, 8'h44, "after overrun");
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "drained");
    send(9'h055, 8, 0, 0, 0, 1);
    settle;
    rchk(urx_pkg::ADDR_STATUS, F_DONE, "overrun cleared");
    rchk(urx_pkg::ADDR_DATA, 8'h55, "data");
    $display("test overrun done");
    wreg(urx_pkg::ADDR_STATUS, F_DBL);
    spb <= urx_pkg::DOUBLE_SPB;
    send(9'h096, 8, 0, 0, 0, 1);
    settle;
    rchk(urx_pkg::ADDR_STATUS, F_DONE | F_DBL, "double speed");
    rchk(urx_pkg::ADDR_DATA, 8'h96, "double data");
    wreg(urx_pkg::ADDR_STATUS, 8'h00);
    spb <= urx_pkg::NORMAL_SPB;
    $display("test double speed done");
    send(9'h077, 8, 0, 0, 0, 1);
    settle;
    chk1("rx_irq", 1'b1, irq);
    wreg(urx_pkg::ADDR_CTRL_B, 8'h00);
    chk1("pin_override", 1'b0, pov);
    chk1("rx_irq", 1'b0, irq);
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "flushed");
    wreg(urx_pkg::ADDR_CTRL_B, C_REN);
    send(9'h088, 8, 0, 0, 0, 1);
    repeat (200) @(posedge clk);
    wreg(urx_pkg::ADDR_CTRL_B, 8'h00);
    settle;
    wreg(urx_pkg::ADDR_CTRL_B, C_REN);
    rchk(urx_pkg::ADDR_STATUS, 8'h00, "dropped frame");
    rchk(urx_pkg::ADDR_DATA, 8'h00, "dropped data");
    $display("test disable done");
    close_out;
  end
endmodule
